// ==== logic/wwdt_pkg.sv ====
// package of constants for the windowed watchdog timer
`default_nettype none
package wwdt_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_PERIOD_CTRL  = 12'h000;
   localparam logic [11:0] ADDR_CLK_OPEN     = 12'h004;
   localparam logic [11:0] ADDR_PRESCALE_CNT = 12'h008;
   localparam logic [11:0] ADDR_COUNTER_STAT = 12'h00C;
   localparam logic [11:0] ADDR_POWER_CTRL   = 12'h010;
   // mode configuration codes
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_SW     = 2'h1;
   localparam logic [1:0] MODE_AWAKE  = 2'h2;
   localparam logic [1:0] MODE_ALWAYS = 2'h3;
   // period select codes
   localparam logic [4:0] PS_SW_CODE  = 5'h1F;
   localparam logic [4:0] PS_RESET    = 5'h0B;
   localparam logic [4:0] PS_MAX      = 5'h12;
   localparam logic [4:0] PS_MIN_LOG2 = 5'h05;
   // window and clock select codes
   localparam logic [2:0] WIN_SW_CODE   = 3'h7;
   localparam logic [2:0] WIN_FULL      = 3'h7;
   localparam logic [2:0] CS_SW_CODE    = 3'h7;
   localparam logic [2:0] CS_LFO        = 3'h0;
   localparam logic [2:0] CS_MFO        = 3'h1;
   localparam logic [2:0] CS_SECONDARY_OSC       = 3'h2;
   localparam logic [2:0] CS_RESET      = 3'h0;
   // field positions
   localparam int PS_LSB   = 1;
   localparam int SWEN_BIT = 0;
   localparam int CS_LSB   = 4;
   localparam int WIN_LSB  = 0;
   // counter widths
   localparam int PRE_W = 18;
   localparam int CNT_W = 5;
   localparam int TOT_W = PRE_W + CNT_W;
endpackage : wwdt_pkg
`default_nettype wire

// ==== logic/wwdt_core.sv ====
// windowed watchdog timer core with apb register slave
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module wwdt_core
(
   // clock and reset
   input  wire  logic        mclk,
   input  wire  logic        rst,
   input  wire  logic        por,
   // configuration word
   input  wire  logic [1:0]  watchdog_mode_config,
   input  wire  logic [4:0]  period_select_config,
   input  wire  logic [2:0]  window_size_config,
   input  wire  logic [2:0]  timer_clock_select_config,
   // oscillator ticks, one cycle each
   input  wire  logic        low_freq_osc,
   input  wire  logic        mid_freq_osc,
   input  wire  logic        secondary_osc,
   // core and power events
   input  wire  logic        watchdog_clear_instr,
   input  wire  logic        sleep_active,
   input  wire  logic        osc_startup_timer,
   input  wire  logic        osc_fail,
   // apb slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [11:0] paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // reset, wake and status flag outputs
   output logic              wdt_reset,
   output logic              wdt_wake,
   output logic              timeout_flag_n,
   output logic              powerdown_flag_n,
   output logic              watchdog_reset_flag_n,
   output logic              window_violation_n
);
   import wwdt_pkg::*;

   logic [4:0]       period_select_q;
   logic             swen_q;
   logic [2:0]       clk_sel_q;
   logic [2:0]       win_sel_q;
   logic [TOT_W-1:0] count_q;
   logic             armed_q;
   logic             sleep_q;
   logic             rst_q;
   logic             wake_q;
   logic             to_n_q;
   logic             pd_n_q;
   logic             watchdog_reset_flag_n_n_q;
   logic             wv_n_q;
   logic [31:0]      rdata_q;

   // bus decode
   wire acc        = psel & penable;
   wire wr         = acc & pwrite;
   wire rd         = acc & ~pwrite;
   wire hit_pc     = paddr == ADDR_PERIOD_CTRL;
   wire hit_co     = paddr == ADDR_CLK_OPEN;
   wire hit_pre    = paddr == ADDR_PRESCALE_CNT;
   wire hit_cs     = paddr == ADDR_COUNTER_STAT;
   wire hit_pw     = paddr == ADDR_POWER_CTRL;
   wire mapped     = hit_pc | hit_co | hit_pre | hit_cs | hit_pw;
   wire wr_pc      = wr & hit_pc;
   wire wr_co      = wr & hit_co;
   wire wr_pw      = wr & hit_pw;
   // arming is a read of the period control register
   wire arm_read   = rd & hit_pc;

   wire ps_lock    = period_select_config != PS_SW_CODE;
   wire cs_lock    = timer_clock_select_config != CS_SW_CODE;
   wire win_lock   = window_size_config != WIN_SW_CODE;

   // software bit only in mode 01
   wire enabled =
      (watchdog_mode_config == MODE_ALWAYS) |
      ((watchdog_mode_config == MODE_AWAKE) & ~sleep_active) |
      ((watchdog_mode_config == MODE_SW) & swen_q);

   // clock source; 111 and others give no tick
   wire [2:0] eff_cs = cs_lock ? timer_clock_select_config : clk_sel_q;
   wire tick = (eff_cs == CS_LFO)  ? low_freq_osc :
               (eff_cs == CS_MFO)  ? mid_freq_osc :
               (eff_cs == CS_SECONDARY_OSC) ? secondary_osc : 1'b0;

   // ratio log2; reserved codes fall to 1:32
   wire [4:0] ps_code = (period_select_q > PS_MAX) ? 5'h00 : period_select_q;
   wire [4:0] log2r   = ps_code + PS_MIN_LOG2;
   // combined prescaler and counter reaching the ratio
   wire [TOT_W-1:0] last = (TOT_W'(1) << log2r) - TOT_W'(1);

   wire [2:0] eff_win = win_lock ? window_size_config : win_sel_q;
   wire [3:0] closed8 = 4'h7 - {1'b0, eff_win};
   // open once count passes the closed eighths
   wire [TOT_W+3:0] cnt8  = {1'b0, count_q, 3'h0};
   wire [TOT_W+3:0] shut  = {4'h0, TOT_W'(closed8)} << log2r;
   wire win_open = (eff_win == WIN_FULL) | (cnt8 >= shut);

   wire clr_evt   = watchdog_clear_instr & enabled;
   wire violation = clr_evt & (~armed_q | ~win_open);
   wire valid_clr = clr_evt & ~violation;
   // timeout tick; an accepted clear landing on that tick wins over it
   wire overflow  = enabled & tick & (count_q == last) & ~valid_clr;
   wire sleep_chg = sleep_active ^ sleep_q;
   // sleep timeout wakes; awake timeout resets
   wire sleep_to  = overflow & sleep_active;
   wire awake_to  = overflow & ~sleep_active;

   // osc fail clears, divider change has no input here
   wire clr_count = valid_clr | sleep_chg | ~enabled | osc_startup_timer |
                    wr_pc | wr_co | osc_fail | overflow | violation;

   // counter, held clear by any clearing event
   always_ff @(posedge mclk) begin
      if (rst | clr_count) begin
         count_q <= '0;
      end else if (tick) begin
         count_q <= count_q + TOT_W'(1);
      end
   end

   // arming read sets, clears disarm; arming read wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (arm_read) begin
         armed_q <= 1'b1;
      end else if (clr_count) begin
         armed_q <= 1'b0;
      end
   end

   // control registers; reset loads configured or default
   always_ff @(posedge mclk) begin
      if (rst) begin
         period_select_q <= ps_lock ? period_select_config : PS_RESET;
         swen_q          <= 1'b0;
         clk_sel_q       <= CS_RESET;
         win_sel_q       <= window_size_config;
      end else begin
         if (wr_pc & ~ps_lock) begin
            period_select_q <= pwdata[PS_LSB +: 5];
         end
         if (wr_pc) begin
            swen_q <= pwdata[SWEN_BIT];
         end
         if (wr_co & ~cs_lock) begin
            clk_sel_q <= pwdata[CS_LSB +: 3];
         end
         if (wr_co & ~win_lock) begin
            win_sel_q <= pwdata[WIN_LSB +: 3];
         end
      end
   end

   // sleep edge tracking and one-cycle reset and wake pulses
   always_ff @(posedge mclk) begin
      if (rst) begin
         sleep_q <= 1'b0;
         rst_q   <= 1'b0;
         wake_q  <= 1'b0;
      end else begin
         sleep_q <= sleep_active;
         rst_q   <= awake_to | violation;
         wake_q  <= sleep_to;
      end
   end

   // violation flag; por sets, violation wins over write
   always_ff @(posedge mclk) begin
      if (por) begin
         wv_n_q <= 1'b1;
      end else if (violation) begin
         wv_n_q <= 1'b0;
      end else if (wr_pw) begin
         wv_n_q <= pwdata[1] | wv_n_q;
      end
   end

   // status flags; hardware event wins over firmware set
   always_ff @(posedge mclk) begin
      if (por) begin
         to_n_q   <= 1'b1;
         pd_n_q   <= 1'b1;
         watchdog_reset_flag_n_n_q <= 1'b1;
      end else if (overflow) begin
         to_n_q   <= 1'b0;
         pd_n_q   <= ~sleep_active;
         watchdog_reset_flag_n_n_q <= 1'b0;
      end else if (valid_clr) begin
         to_n_q   <= 1'b1;
         pd_n_q   <= 1'b1;
      end else if (wr_pw) begin
         watchdog_reset_flag_n_n_q <= pwdata[0] | watchdog_reset_flag_n_n_q;
      end
   end

   // read mux; armed bit beside counter and top prescale bits
   wire [31:0] rd_mux =
      hit_pc  ? {26'h0, period_select_q, swen_q} :
      hit_co  ? {25'h0, eff_cs, 1'b0, eff_win} :
      hit_pre ? {14'h0, count_q[PRE_W-1:0]} :
      hit_cs  ? {25'h0, count_q[TOT_W-1 -: 4], armed_q, count_q[PRE_W-1 -: 2]} :
      hit_pw  ? {30'h0, wv_n_q, watchdog_reset_flag_n_n_q} : 32'h0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q <= 32'h0;
      end else if (psel & ~penable & ~pwrite) begin
         rdata_q <= rd_mux;
      end
   end

   // zero-wait slave; unmapped addresses answer with error
   assign pready                = 1'b1;
   assign pslverr               = acc & ~mapped;
   assign prdata                = rdata_q;
   assign wdt_reset             = rst_q;
   assign wdt_wake              = wake_q;
   assign timeout_flag_n        = to_n_q;
   assign powerdown_flag_n      = pd_n_q;
   assign watchdog_reset_flag_n = watchdog_reset_flag_n_n_q;
   assign window_violation_n    = wv_n_q;

   // assertions
   sequence s_bad_clear;
      watchdog_clear_instr && enabled && !armed_q;
   endsequence

   a_unarmed_clear_resets: assert property (@(posedge mclk) disable iff (rst)
      s_bad_clear |=> wdt_reset && !window_violation_n)
      else $error("unarmed clear did not reset");
   a_closed_window_reset: assert property (@(posedge mclk) disable iff (rst)
      (clr_evt && armed_q && !win_open) |=> wdt_reset)
      else $error("closed window clear did not reset");
   a_mode_off_idle: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_mode_config == MODE_OFF) |-> ##1 (count_q == '0))
      else $error("count moved in mode 00");
   a_sleep_no_reset: assert property (@(posedge mclk) disable iff (rst)
      sleep_to |=> wdt_wake && !wdt_reset && !watchdog_reset_flag_n)
      else $error("sleep timeout mishandled");
   a_awake_ovf_reset: assert property (@(posedge mclk) disable iff (rst)
      awake_to |=> wdt_reset && !timeout_flag_n)
      else $error("awake overflow did not reset");
   a_write_clears_cnt: assert property (@(posedge mclk) disable iff (rst)
      (wr_pc || wr_co) |=> count_q == '0)
      else $error("control write did not clear count");
   a_reserved_ratio: assert property (@(posedge mclk) disable iff (rst)
      (period_select_q > PS_MAX) |-> last == TOT_W'(31))
      else $error("reserved code not 1:32");
   a_arm_then_disarm: assert property (@(posedge mclk) disable iff (rst)
      (valid_clr && !arm_read) |=> !armed_q)
      else $error("clear did not disarm");
   a_period_lock: assert property (@(posedge mclk) disable iff (rst)
      ps_lock |-> ##1 (period_select_q == $past(period_select_q) || $past(rst)))
      else $error("locked period select changed");

   // second step of a clear: armed and inside an open window
   sequence s_good_clear;
      watchdog_clear_instr && enabled && armed_q && win_open;
   endsequence

   // enable by mode, the events that clear the count, the count bound and the reserved clock codes
   a_always_counts: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_mode_config == MODE_ALWAYS && tick && !clr_count) |=>
      count_q == $past(count_q) + TOT_W'(1))
      else $error("count stalled in mode 11");
   a_awake_off_sleep: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_mode_config == MODE_AWAKE && sleep_active) |=> count_q == '0)
      else $error("count moved asleep in mode 10");
   a_sw_gate_off: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_mode_config == MODE_SW && !swen_q) |=> count_q == '0)
      else $error("count moved with software enable off");
   a_off_no_reset: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_mode_config == MODE_OFF) |=> !wdt_reset && !wdt_wake)
      else $error("reset or wake in mode 00");
   a_disabled_ignores: assert property (@(posedge mclk) disable iff (rst)
      (watchdog_clear_instr && !enabled) |=> !wdt_reset)
      else $error("clear while disabled caused reset");
   a_sleep_edge_clear: assert property (@(posedge mclk) disable iff (rst)
      sleep_chg |=> count_q == '0)
      else $error("sleep edge did not clear count");
   a_ost_holds_clear: assert property (@(posedge mclk) disable iff (rst)
      osc_startup_timer |=> count_q == '0)
      else $error("count moved during start-up timer");
   a_osc_fail_clear: assert property (@(posedge mclk) disable iff (rst)
      osc_fail |=> count_q == '0)
      else $error("oscillator failure did not clear count");
   a_count_bounded: assert property (@(posedge mclk) disable iff (rst)
      count_q <= last)
      else $error("count passed the selected ratio");
   a_reserved_src_idle: assert property (@(posedge mclk) disable iff (rst)
      (eff_cs > CS_SECONDARY_OSC) |-> !tick)
      else $error("reserved clock select produced ticks");

   // clear, arming, flag and pulse behaviour
   a_good_clear_restarts: assert property (@(posedge mclk) disable iff (rst)
      s_good_clear |=> count_q == '0 && !wdt_reset)
      else $error("accepted clear did not restart count");
   a_arm_read_sets: assert property (@(posedge mclk) disable iff (rst)
      arm_read |=> armed_q)
      else $error("arming read did not arm");
   a_violation_flag: assert property (@(posedge mclk) disable iff (rst)
      violation |=> !window_violation_n)
      else $error("violation flag not cleared");
   a_sleep_to_flags: assert property (@(posedge mclk) disable iff (rst)
      sleep_to |=> !timeout_flag_n && !powerdown_flag_n)
      else $error("sleep timeout flags wrong");
   a_wake_awake_quiet: assert property (@(posedge mclk) disable iff (rst)
      awake_to |=> !wdt_wake && powerdown_flag_n)
      else $error("awake timeout gave wake or power-down");
endmodule // wwdt_core
`default_nettype wire

// ==== bench/wwdt_core_tb.sv ====
// self-checking bench for the windowed watchdog core
`timescale 1ns/100ps
`default_nettype none
module wwdt_core_tb;
   import wwdt_pkg::*;
   `define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin errors++; \
      $display("wrong value %s exp %0h got %0h", n, e, g); end end
   // stimulus and observed signals
   logic        mclk, rst, por, tick, clr, sleep_active, osc_startup_timer, osc_fail;
   logic        psel, penable, pwrite, pready, pslverr, wdt_reset, wdt_wake;
   logic        timeout_flag_n, powerdown_flag_n, watchdog_reset_flag_n, window_violation_n;
   logic [1:0]  watchdog_mode_config;
   logic [4:0]  period_select_config;
   logic [2:0]  window_size_config, timer_clock_select_config;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        rs, wk, er;
   logic [2:0]  src_on;
   int          errors, comparisons, cyc;

   // clock, and a time-base tick every second cycle
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) tick <= ~tick;

   wwdt_core uut (
      .mclk, .rst, .por, .watchdog_mode_config, .period_select_config, .window_size_config,
      .timer_clock_select_config, .low_freq_osc(tick & src_on[0]),
      .mid_freq_osc(tick & src_on[1]), .secondary_osc(tick & src_on[2]),
      .watchdog_clear_instr(clr), .sleep_active, .osc_startup_timer,
      .osc_fail, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .wdt_reset, .wdt_wake, .timeout_flag_n, .powerdown_flag_n, .watchdog_reset_flag_n,
      .window_violation_n);

   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic pulse_clr();
      @(posedge mclk);
      clr <= 1'h1;
      @(posedge mclk);
      clr <= 1'h0;
   endtask

   // fresh reset with power-on, so the flags start set
   task automatic restart(input logic [1:0] m, input logic [4:0] pc);
      @(posedge mclk);
      rst <= 1'h1;
      por <= 1'h1;
      sleep_active <= 1'h0;
      osc_startup_timer <= 1'h0;
      osc_fail <= 1'h0;
      src_on <= 3'h1;
      watchdog_mode_config <= m;
      period_select_config <= pc;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      por <= 1'h0;
   endtask

   // bounded wait for a reset or wake pulse; cyc equals lim if none came
   task automatic wait_out(input int lim);
      rs = 1'h0;
      wk = 1'h0;
      for (cyc = 0; cyc < lim; cyc++) begin
         @(posedge mclk);
         rs = wdt_reset;
         wk = wdt_wake;
         if (rs === 1'h1 || wk === 1'h1) break;
      end
   endtask

   task automatic t_regs();
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h0, ADDR_PERIOD_CTRL, 32'h0);
      `CHK("period_rst", 32'h16, rd)
      apb(1'h0, ADDR_CLK_OPEN, 32'h0);
      `CHK("clk_open_rst", 32'h07, rd)
      apb(1'h0, 12'h020, 32'h0);
      `CHK("unmapped_err", 1'h1, er)
      `CHK("unmapped_rd", 32'h0, rd)
      // locked period field ignores the write
      restart(MODE_ALWAYS, 5'h02);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
      apb(1'h0, ADDR_PERIOD_CTRL, 32'h0);
      `CHK("period_lock", 32'h04, rd)
      // configured clock and window fields lock their register bits
      window_size_config <= 3'h3;
      timer_clock_select_config <= 3'h2;
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_CLK_OPEN, 32'h07);
      apb(1'h0, ADDR_CLK_OPEN, 32'h0);
      `CHK("clk_open_lock", 32'h23, rd)
      window_size_config <= 3'h7;
      timer_clock_select_config <= 3'h7;
   endtask

   task automatic t_period();
      int codes[4] = '{0, 1, 19, 31};
      int ex;
      foreach (codes[i]) begin
         restart(MODE_ALWAYS, 5'h1F);
         apb(1'h1, ADDR_PERIOD_CTRL, {26'h0, 5'(codes[i]), 1'h0});
         wait_out(400);
         ex = 64 << (codes[i] > 18 ? 0 : codes[i]);
         `CHK("timeout_rst", 1'h1, rs)
         `CHK("timeout_time", 1'h1, 1'(cyc > ex - 8 && cyc < ex + 8))
      end
   endtask

   task automatic t_modes();
      logic [1:0] m[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
      logic       sw[5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
      foreach (m[i]) begin
         restart(m[i], 5'h1F);
         apb(1'h1, ADDR_PERIOD_CTRL, {31'h0, sw[i]});
         wait_out(150);
         `CHK("mode_fire", 1'(i >= 2), rs)
      end
   endtask

   task automatic t_sleep();
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
      sleep_active <= 1'h1;
      wait_out(150);
      `CHK("sleep_wake", 1'h1, wk)
      `CHK("sleep_no_rst", 1'h0, rs)
      repeat (2) @(posedge mclk);
      `CHK("to_flag", 1'h0, timeout_flag_n)
      `CHK("pd_flag", 1'h0, powerdown_flag_n)
      `CHK("watchdog_reset_flag_n_flag", 1'h0, watchdog_reset_flag_n)
      restart(MODE_AWAKE, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
      sleep_active <= 1'h1;
      wait_out(150);
      `CHK("awake_only", 150, cyc)
   endtask

   task automatic t_window();
      // clear without an arming read
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h4);
      pulse_clr();
      wait_out(3);
      `CHK("unarmed_rst", 1'h1, rs)
      @(posedge mclk);
      `CHK("wv_flag", 1'h0, window_violation_n)
      apb(1'h1, ADDR_POWER_CTRL, 32'h3);
      apb(1'h0, ADDR_POWER_CTRL, 32'h0);
      `CHK("wv_set", 32'h3, rd)
      // armed clear while the window is still closed
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h4);
      apb(1'h1, ADDR_CLK_OPEN, 32'h0);
      apb(1'h0, ADDR_PERIOD_CTRL, 32'h0);
      pulse_clr();
      wait_out(3);
      `CHK("closed_rst", 1'h1, rs)
      // armed clear in a fully open window restarts the count
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
      repeat (40) @(posedge mclk);
      apb(1'h0, ADDR_PERIOD_CTRL, 32'h0);
      apb(1'h0, ADDR_COUNTER_STAT, 32'h0);
      `CHK("armed_bit", 1'h1, rd[2])
      pulse_clr();
      apb(1'h0, ADDR_COUNTER_STAT, 32'h0);
      `CHK("disarmed", 1'h0, rd[2])
      wait_out(50);
      `CHK("clr_restart", 50, cyc)
      // armed clear after a half-open window has opened is accepted
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h4);
      apb(1'h1, ADDR_CLK_OPEN, 32'h03);
      repeat (150) @(posedge mclk);
      apb(1'h0, ADDR_PERIOD_CTRL, 32'h0);
      pulse_clr();
      wait_out(150);
      `CHK("open_clr", 150, cyc)
   endtask

   task automatic t_hold();
      for (int k = 0; k < 2; k++) begin
         restart(MODE_ALWAYS, 5'h1F);
         apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
         if (k == 1) osc_fail <= 1'h1;
         else osc_startup_timer <= 1'h1;
         wait_out(150);
         `CHK("held_clear", 150, cyc)
      end
   endtask

   task automatic t_clksel();
      restart(MODE_ALWAYS, 5'h1F);
      apb(1'h1, ADDR_PERIOD_CTRL, 32'h0);
      apb(1'h1, ADDR_CLK_OPEN, 32'h27);
      apb(1'h0, ADDR_CLK_OPEN, 32'h0);
      `CHK("clk_sel_rd", 32'h27, rd)
      wait_out(150);
      `CHK("silent_src", 150, cyc)
      src_on <= 3'h4;
      wait_out(150);
      `CHK("secondary_osc_src", 1'h1, rs)
      apb(1'h1, ADDR_CLK_OPEN, 32'h17);
      wait_out(150);
      `CHK("mid_silent", 150, cyc)
      src_on <= 3'h2;
      wait_out(150);
      `CHK("mid_src", 1'h1, rs)
      src_on <= 3'h7;
      apb(1'h1, ADDR_CLK_OPEN, 32'h77);
      wait_out(150);
      `CHK("reserved_src", 150, cyc)
   endtask

   task automatic final_report();
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      mclk = 1'h0;
      tick = 1'h0;
      src_on = 3'h1;
      {rst, por} = 2'h3;
      {clr, sleep_active, osc_startup_timer, osc_fail} = 4'h0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      watchdog_mode_config = MODE_ALWAYS;
      period_select_config = 5'h1F;
      window_size_config = 3'h7;
      timer_clock_select_config = 3'h7;
      errors = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      por <= 1'h0;
      t_regs();
      t_period();
      t_modes();
      t_sleep();
      t_window();
      t_hold();
      t_clksel();
      final_report();
   end

   // hang guard, well beyond the few thousand cycles the tests need
   initial begin
      #60000;
      errors++;
      final_report();
   end
endmodule // wwdt_core_tb
`default_nettype wire
